// >>> ilc_pkg.sv
// constants and carrier types for the indicator light controller
package ilc_pkg;

  // ---------------------------------------------------------------
  // clock and blink timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned BLINK_MS_20HZ = 50;
  localparam int unsigned BLINK_MS_10HZ = 100;
  localparam int unsigned BLINK_MS_5HZ  = 200;
  localparam int unsigned BLINK_MS_2HZ  = 500;
  // half a blink period, in clock cycles
  localparam int unsigned HALF_20HZ = BLINK_MS_20HZ * MS_CYCLES / 2;
  localparam int unsigned HALF_10HZ = BLINK_MS_10HZ * MS_CYCLES / 2;
  localparam int unsigned HALF_5HZ  = BLINK_MS_5HZ * MS_CYCLES / 2;
  localparam int unsigned HALF_2HZ  = BLINK_MS_2HZ * MS_CYCLES / 2;

  // ---------------------------------------------------------------
  // register map (printed index, byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [29:0] IDX_CFG  = 30'h460;
  localparam logic [29:0] IDX_STS  = 30'h001;
  localparam logic [31:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [31:0] ADDR_STS = {IDX_STS, 2'b00};

  // configuration fields
  localparam logic [15:0] CFG_RESET = 16'h2610;
  localparam int unsigned RATE_LSB  = 12;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned N_IND     = 3;

  // status register bits
  localparam int unsigned STS_LINK = 0;
  localparam int unsigned STS_LOST = 1;
  localparam int unsigned STS_PRBS = 2;

  // ---------------------------------------------------------------
  // indicator source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_LINK      = 4'h0;
  localparam logic [3:0] SRC_LINK_ACT  = 4'h1;
  localparam logic [3:0] SRC_LINK_TX   = 4'h2;
  localparam logic [3:0] SRC_MASTER    = 4'h4;
  localparam logic [3:0] SRC_SLAVE     = 4'h5;
  localparam logic [3:0] SRC_ACT       = 4'h6;
  localparam logic [3:0] SRC_LOST      = 4'h9;
  localparam logic [3:0] SRC_PRBS      = 4'ha;

  // internal phy conditions that feed the indicators
  typedef struct packed {
    logic link_up;
    logic tx_act;
    logic rx_act;
    logic master;
    logic prbs_err;
    logic prbs_cnt_clr;
  } ilc_phy_t;

endpackage

// >>> ilc_top.sv
// indicator light controller with ahb-lite register slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - blink rate field 13:12, reset 5 Hz
// - bits 3:0 select source of indicator a
// - bits 7:4 select source of indicator b
// - bits 11:8 select source of indicator c
// - 0000 link up; 0001 link plus activity
// - 0010 link up plus transmit activity
// - 0100 link up in master role
// - 0101 link up in slave role
// - 0110 activity regardless of link state
// - 1001 link lost, held until status read
// - 1010 prbs error, even single error
// - prbs indication held until counter cleared
module ilc_top
#(
  parameter int unsigned HALF_R0 = ilc_pkg::HALF_20HZ,
  parameter int unsigned HALF_R1 = ilc_pkg::HALF_10HZ,
  parameter int unsigned HALF_R2 = ilc_pkg::HALF_5HZ,
  parameter int unsigned HALF_R3 = ilc_pkg::HALF_2HZ
)
(
  input  wire logic             CLK_SYS,
  input  wire logic             RST_B,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  input  wire ilc_pkg::ilc_phy_t PHY_STAT,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  output logic                  IND_OUT_A,
  output logic                  IND_OUT_B,
  output logic                  IND_OUT_C
);
  import ilc_pkg::*;

  logic [15:0]      cfg_r;
  logic             wr_cfg_r;
  logic             addr_ok;
  logic             rd_sts;
  logic             link_prev_r;
  logic             link_lost_r;
  logic             prbs_lat_r;
  logic [31:0]      cnt_r;
  logic [31:0]      half_lim;
  logic             tick;
  logic             phase_r;
  logic [N_IND-1:0] ind_r;
  logic [N_IND-1:0] ind_nxt;
  logic [3:0]       sel_w [N_IND];
  logic [31:0]      rdata_nxt;

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------

  // a valid address phase; only whole-word singles are expected
  assign addr_ok = HSEL & HREADY & HTRANS[1];
  assign rd_sts  = addr_ok & ~HWRITE & (HADDR == ADDR_STS);

  // remember a configuration write for its data phase
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      wr_cfg_r <= 1'b0;
    else
      wr_cfg_r <= addr_ok & HWRITE & (HADDR == ADDR_CFG);
  end

  // configuration register, written in the data phase
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      cfg_r <= CFG_RESET;
    else if (wr_cfg_r)
      cfg_r <= HWDATA[15:0];
  end

  // read data mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (HADDR == ADDR_CFG)
      rdata_nxt = {16'h0, cfg_r};
    else if (HADDR == ADDR_STS)
    begin
      rdata_nxt[STS_LINK] = PHY_STAT.link_up;
      rdata_nxt[STS_LOST] = link_lost_r;
      rdata_nxt[STS_PRBS] = prbs_lat_r;
    end
  end

  // read data is launched from the address phase
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      HRDATA <= 32'h0;
    else if (addr_ok & ~HWRITE)
      HRDATA <= rdata_nxt;
    else
      HRDATA <= 32'h0;
  end

  // low in reset, then always ready; always okay
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // latched conditions
  // ---------------------------------------------------------------

  // link-lost latch: set on a falling link, cleared by a status read
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      link_prev_r <= 1'b0;
      link_lost_r <= 1'b0;
    end
    else
    begin
      link_prev_r <= PHY_STAT.link_up;
      if (link_prev_r & ~PHY_STAT.link_up)
        link_lost_r <= 1'b1;
      else if (rd_sts)
        link_lost_r <= 1'b0;
    end
  end

  // prbs error latch: one error sets it, counter clear drops it
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      prbs_lat_r <= 1'b0;
    else if (PHY_STAT.prbs_err)
      prbs_lat_r <= 1'b1;
    else if (PHY_STAT.prbs_cnt_clr)
      prbs_lat_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // blink divider
  // ---------------------------------------------------------------

  // half period chosen by the rate field
  always_comb
  begin
    unique case (cfg_r[RATE_LSB +: 2])
      2'b00: half_lim = 32'(HALF_R0);
      2'b01: half_lim = 32'(HALF_R1);
      2'b10: half_lim = 32'(HALF_R2);
      2'b11: half_lim = 32'(HALF_R3);
    endcase
  end

  // a rate change that lowers the limit wraps at once
  assign tick = (cnt_r >= half_lim - 32'h1);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      cnt_r <= 32'h0;
    else if (tick)
      cnt_r <= 32'h0;
    else
      cnt_r <= cnt_r + 32'h1;
  end

  // blink phase toggles once per half period
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      phase_r <= 1'b0;
    else if (tick)
      phase_r <= ~phase_r;
  end

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------

  // level of one indicator for a given source code
  function automatic logic src_level(
    input logic [3:0] sel,
    input ilc_phy_t   p,
    input logic       lost,
    input logic       prbs,
    input logic       ph
  );
    logic act;
    logic lvl;
    act = p.tx_act | p.rx_act;
    lvl = 1'b0;
    case (sel)
      SRC_LINK:     lvl = p.link_up;
      SRC_LINK_ACT: lvl = p.link_up & (act ? ph : 1'b1);
      SRC_LINK_TX:  lvl = p.link_up & (p.tx_act ? ph : 1'b1);
      SRC_MASTER:   lvl = p.link_up & p.master;
      SRC_SLAVE:    lvl = p.link_up & ~p.master;
      SRC_ACT:      lvl = act & ph;
      SRC_LOST:     lvl = lost;
      SRC_PRBS:     lvl = prbs | p.prbs_err;
      default:      lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // one selector and one registered output per indicator
  generate
    for (genvar k = 0; k < N_IND; k++)
    begin : g_ind
      assign sel_w[k]   = cfg_r[k*SEL_W +: SEL_W];
      assign ind_nxt[k] = src_level(sel_w[k], PHY_STAT, link_lost_r,
                                    prbs_lat_r, phase_r);
      always_ff @(posedge CLK_SYS)
      begin
        if (!RST_B)
          ind_r[k] <= 1'b0;
        else
          ind_r[k] <= ind_nxt[k];
      end
    end
  endgenerate

  // fixed field placement for b and c
  assign IND_OUT_A = ind_r[0];
  assign IND_OUT_B = ind_r[1];
  assign IND_OUT_C = ind_r[2];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  a_cfg_reset_val: assert property (
    @(posedge CLK_SYS) !RST_B |=> (cfg_r[13:12] == 2'b10) &&
      (sel_w[0] == 4'h0) && (sel_w[1] == 4'h1) && (sel_w[2] == 4'h6))
    else $error("configuration reset value wrong");

  a_sel_b_field: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    wr_cfg_r |=> sel_w[1] == $past(HWDATA[7:4]))
    else $error("indicator b selector not taken from bits 7:4");

  a_sel_c_field: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    wr_cfg_r |=> sel_w[2] == $past(HWDATA[11:8]))
    else $error("indicator c selector not taken from bits 11:8");

  a_link_only_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    sel_w[0] == SRC_LINK |=> IND_OUT_A == $past(PHY_STAT.link_up))
    else $error("link source does not follow link");

  a_tx_needs_link: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] == SRC_LINK_TX) && !PHY_STAT.link_up |=> !IND_OUT_A)
    else $error("transmit source lit without link");

  a_master_role: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] == SRC_MASTER) |=>
      IND_OUT_A == $past(PHY_STAT.link_up & PHY_STAT.master))
    else $error("master source wrong");

  a_slave_role: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] == SRC_SLAVE) |=>
      IND_OUT_A == $past(PHY_STAT.link_up & ~PHY_STAT.master))
    else $error("slave source wrong");

  a_act_idle_off: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] == SRC_ACT) && !PHY_STAT.tx_act && !PHY_STAT.rx_act
      |=> !IND_OUT_A)
    else $error("activity source lit while idle");

  a_lost_hold: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    link_lost_r && !rd_sts |=> link_lost_r)
    else $error("link-lost latch dropped without status read");

  a_lost_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    link_prev_r && !PHY_STAT.link_up |=> link_lost_r)
    else $error("link loss not latched");

  a_prbs_single: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] == SRC_PRBS) && PHY_STAT.prbs_err |=> IND_OUT_A)
    else $error("single prbs error not shown");

  a_prbs_hold: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    prbs_lat_r && !PHY_STAT.prbs_cnt_clr |=> prbs_lat_r)
    else $error("prbs latch dropped before counter clear");

  a_rsvd_off: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    (sel_w[0] inside {4'h3, 4'h7, 4'h8, [4'hb:4'hf]}) |=> !IND_OUT_A)
    else $error("reserved source drives indicator");

  a_blink_tick: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    $changed(phase_r) |-> $past(tick) && (cnt_r == 32'h0))
    else $error("blink phase moved without divider tick");

endmodule

`default_nettype wire

// >>> ilc_lamp_model.sv
// board lamp model: measures how long a lamp stays lit
`timescale 1ns/10ps
`default_nettype none
module ilc_lamp_model
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        lamp,
  output logic      [15:0] last_on,
  output logic      [15:0] pulses
);
  logic [15:0] run_r;

  // ---------------------------------------------------------------
  // length of the last lit stretch and count of flashes
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      run_r   <= 16'h0000;
      last_on <= 16'h0000;
      pulses  <= 16'h0000;
    end
    else if (lamp)
      run_r <= run_r + 16'h0001;
    else
    begin
      if (run_r != 16'h0000)
      begin
        last_on <= run_r; // a partial stretch is overwritten later
        pulses  <= pulses + 16'h0001;
      end
      run_r <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// >>> test_phy_status_led_control.sv
// testbench of the indicator light controller
`timescale 1ns/10ps
`default_nettype none
module test_phy_status_led_control;
  import ilc_pkg::*;
  localparam int unsigned HALF [4] = '{4, 6, 8, 10};
  logic             clk;
  logic             rst_b;
  logic             hsel;
  logic      [31:0] haddr;
  logic      [1:0]  htrans;
  logic             hwrite;
  logic      [31:0] hwdata;
  ilc_phy_t         phy;
  logic      [31:0] hrdata;
  logic             hreadyout;
  logic             hresp;
  logic             ind_a;
  logic             ind_b;
  logic             ind_c;
  logic      [15:0] last_on;
  logic      [15:0] pulses;
  logic      [3:0]  rsv [7] = '{4'h7, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  int               fails = 0;
  int               n_checks = 0;

  ilc_top #(.HALF_R0(4), .HALF_R1(6), .HALF_R2(8), .HALF_R3(10))
    ilc_top_inst (.CLK_SYS(clk), .RST_B(rst_b), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hreadyout), .PHY_STAT(phy),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .IND_OUT_A(ind_a), .IND_OUT_B(ind_b), .IND_OUT_C(ind_c));
  ilc_lamp_model ilc_lamp_model_inst (.clk(clk), .rst_b(rst_b),
    .lamp(ind_a), .last_on(last_on), .pulses(pulses));

  // ---------------------------------------------------------------
  // clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    fails++;
    final_report();
  end
  task automatic final_report;
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // ahb-lite single word transfer, waits on ready in both phases
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  // link, tx, rx, master levels; pulse bits stay low
  task automatic phy_set(input logic [3:0] v);
    @(posedge clk);
    phy <= {v, 2'b00};
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    phy[b] <= 1'b1;
    @(posedge clk);
    phy[b] <= 1'b0;
  endtask
  // lamps a,b,c under mask, checked for n cycles after settling
  task automatic ind(input logic [2:0] e, input logic [2:0] m = 3'b111,
                     input int n = 1);
    repeat (3) @(posedge clk);
    repeat (n)
    begin
      chk({29'h0, {ind_a, ind_b, ind_c} & m}, {29'h0, e});
      @(posedge clk);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_b  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    phy    = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_CFG, 32'h0000_2610);
    rd(32'h0000_0008, 32'h0);
    wr(ADDR_CFG, 32'hffff_c450);
    rd(ADDR_CFG, 32'h0000_c450);
    phy_set(4'b1001);
    ind(3'b101);
    phy_set(4'b1000);
    ind(3'b110);
    phy_set(4'b0001);
    ind(3'b000);
    // reserved codes 7, 8 and b to f stay dark with link, tx, rx and master all high
    phy_set(4'b1111);
    foreach (rsv[i])
    begin
      wr(ADDR_CFG, {20'h0, rsv[i], rsv[i], rsv[i]});
      ind(3'b000);
    end
    // link lost latch: a lost, b link, c activity
    wr(ADDR_CFG, 32'h0000_0609);
    phy_set(4'b1000);
    rd(ADDR_STS, 32'h0000_0003);
    ind(3'b010);
    phy_set(4'b0000);
    ind(3'b100, 3'b111, 8);
    phy_set(4'b1000);
    ind(3'b110);
    rd(ADDR_STS, 32'h0000_0003);
    ind(3'b010);
    // prbs latch on a single error, held until counter clear
    wr(ADDR_CFG, 32'h0000_000a);
    pulse(1);
    ind(3'b111, 3'b111, 8);
    pulse(0);
    ind(3'b011);
    // blink rates: a activity, b link+act, c link+tx
    phy_set(4'b0100);
    for (int r = 0; r < 4; r++)
    begin
      wr(ADDR_CFG, {18'h0, r[1:0], 12'h216});
      repeat (6 * HALF[r] + 8) @(posedge clk);
      chk({16'h0, last_on}, HALF[r]);
    end
    phy_set(4'b1010);
    ind(3'b001, 3'b001, 24);
    phy_set(4'b1000);
    ind(3'b011, 3'b111, 24);
    // link with transmit: all three blink together, off half a period on
    phy_set(4'b1100);
    repeat (3) @(posedge clk);
    while (!ind_a) @(posedge clk);
    chk({29'h0, ind_a, ind_b, ind_c}, 32'h7);
    repeat (HALF[3]) @(posedge clk);
    chk({29'h0, ind_a, ind_b, ind_c}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
